// >>> rtl/swpac_defines.svh
// constants for the write-port and address capture block
// assumes inclusion by bare name from files under rtl/
// What this block does
// - write data captured on both input clock edges; 18 or 36 bits wide
// - write select low at positive edge starts a write
// - write select high deselects port; data ignored, no write
// - byte selects sampled on both edges choose lanes of each beat
// - lane with byte select high keeps its stored contents
// - each byte select covers a 9-bit lane, select 0 at bits 8..0
// - byte selects arrive on the same edge as their data beat
// - shared address: read address at positive edge, write at complementary
// - 19 address bits in both narrow and wide; no half select
// - deselected port ignores address, latches none
// - read select low at positive edge starts two-beat read
// - every access begins at a positive-edge phase
`ifndef SWPAC_DEFINES_SVH
`define SWPAC_DEFINES_SVH
`define SWPAC_DATA_W      36
`define SWPAC_LANE_W      9
`define SWPAC_LANES       4
`define SWPAC_ADDR_W      19
`define SWPAC_FIFO_DEPTH  16
`define SWPAC_BEATS       2
`endif

// >>> rtl/swpac_pkg.sv
// types for the write-port and address capture block
// assumes swpac_defines.svh sits beside it
`include "swpac_defines.svh"
package swpac_pkg;
    typedef enum logic [1:0] {SWPAC_IDLE, SWPAC_BEAT1} swpac_wstate_t;
    typedef logic [`SWPAC_DATA_W-1:0] swpac_data_t;
    typedef logic [`SWPAC_ADDR_W-1:0] swpac_addr_t;
    typedef logic [`SWPAC_LANES-1:0]  swpac_lanes_t;
endpackage : swpac_pkg

// >>> rtl/swpac_stream_if.sv
// valid/ready word stream between the capture logic and its fifo
// assumes a single clock shared by both ends
`timescale 1ns/10ps
`default_nettype none
interface swpac_stream_if #(parameter int WIDTH = 8);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : swpac_stream_if
`default_nettype wire

// >>> rtl/swpac_fifo.sv
// parameterised fifo, registered read data
// assumes one clock, asynchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module swpac_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic clk,       // clock
    input  wire logic rst_n,     // reset
    swpac_stream_if.snk  in_s,   // fill side
    swpac_stream_if.src  out_s   // drain side
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    logic             ov_q;
    logic [WIDTH-1:0] od_q;
    wire              push = in_s.valid && in_s.ready;
    wire              pop  = (cnt_q != '0) && (!ov_q || out_s.ready);
    wire              full = (cnt_q == (AW+1)'(DEPTH));

    assign in_s.ready  = !full;
    assign out_s.valid = ov_q;
    assign out_s.data  = od_q;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_s.data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
            ov_q  <= 1'b0;
            od_q  <= '0;
        end else begin
            wp_q  <= push ? AW'(wp_q + 1'b1) : wp_q;
            rp_q  <= pop ? AW'(rp_q + 1'b1) : rp_q;
            cnt_q <= (AW+1)'(cnt_q + (AW+1)'(push) - (AW+1)'(pop));
            if (pop) begin
                od_q <= mem_q[rp_q];
                ov_q <= 1'b1;
            end else if (out_s.ready) begin
                ov_q <= 1'b0;
            end
        end
    end
endmodule : swpac_fifo
`default_nettype wire

// >>> rtl/swpac_top.sv
// write-port input capture and shared address latch of a dual-port burst memory
// assumes clk is the internal double-rate clock; phase_k marks positive input edges
// assumes pins come from outside the clock domain and are synchronised here
`timescale 1ns/10ps
`default_nettype none
`include "swpac_defines.svh"
module swpac_top
    import swpac_pkg::*;
(
    input  wire logic         clk,                      // 10 MHz clock
    input  wire logic         rst_n,                    // async reset, active low
    input  wire logic         phase_k,                  // high on positive input-clock edge
    input  wire logic         write_port_select_n,      // write port select
    input  wire logic         read_port_select_n,       // read port select
    input  wire swpac_lanes_t byte_lane_write_select_n, // byte lane selects
    input  wire swpac_addr_t  addr,                     // shared address bus
    input  wire swpac_data_t  wdata,                    // write data bus
    input  wire logic         wide_cfg,                 // 1: 36-bit, 0: 18-bit
    input  wire logic         wr_ready,                 // array accepts write beat
    output logic              wr_valid,                 // write beat valid
    output swpac_addr_t       wr_addr,                  // write address
    output logic              wr_beat,                  // beat index in burst
    output swpac_data_t       wr_data,                  // beat data
    output logic [`SWPAC_DATA_W-1:0] wr_bitmask,        // bits to write
    output logic              rd_start,                 // read burst start pulse
    output swpac_addr_t       rd_addr,                  // read address
    output logic              stall                     // fifo full, beat dropped
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int PW = 3 + `SWPAC_LANES + `SWPAC_ADDR_W + `SWPAC_DATA_W + 1;
    logic [PW-1:0] s1_q;
    logic [PW-1:0] s2_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // idle pins: both selects high, complementary phase
            s1_q <= {3'h6, {`SWPAC_LANES{1'b1}}, {(PW-3-`SWPAC_LANES){1'b0}}};
            s2_q <= {3'h6, {`SWPAC_LANES{1'b1}}, {(PW-3-`SWPAC_LANES){1'b0}}};
        end else begin
            s1_q <= {write_port_select_n, read_port_select_n, phase_k,
                     byte_lane_write_select_n, addr, wdata, wide_cfg};
            s2_q <= s1_q;
        end
    end
    wire          wps_n = s2_q[PW-1];
    wire          rps_n = s2_q[PW-2];
    wire          ph_k  = s2_q[PW-3];
    wire swpac_lanes_t bws_n = s2_q[PW-4 -: `SWPAC_LANES];
    wire swpac_addr_t  a_s   = s2_q[PW-4-`SWPAC_LANES -: `SWPAC_ADDR_W];
    wire swpac_data_t  d_s   = s2_q[`SWPAC_DATA_W:1];
    wire          wide  = s2_q[0];

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    swpac_wstate_t st_q;
    swpac_wstate_t st_d;
    wire wr_go  = ph_k && !wps_n;
    wire rd_go  = ph_k && !rps_n;
    wire beat_k  = (st_q == SWPAC_IDLE) && wr_go;
    wire beat_kb = (st_q == SWPAC_BEAT1) && !ph_k;
    wire take   = beat_k || beat_kb;
    // both widths use all 19 address bits: amask is all ones, no half select
    wire [`SWPAC_ADDR_W-1:0] amask = wide ? {`SWPAC_ADDR_W{1'b1}}
                                          : {`SWPAC_ADDR_W{1'b1}};

    always_comb begin
        st_d = st_q;
        case (st_q)
            SWPAC_IDLE: begin
                if (wr_go) begin
                    st_d = SWPAC_BEAT1;
                end
            end
            SWPAC_BEAT1: begin
                if (!ph_k) begin
                    st_d = SWPAC_IDLE;
                end
            end
            default: begin
                st_d = SWPAC_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // lane mask
    // ------------------------------------------------------------
    logic [`SWPAC_DATA_W-1:0] mask_w;
    always_comb begin
        mask_w = '0;
        for (int i = 0; i < `SWPAC_LANES; i++) begin
            if (!bws_n[i] && (wide || i < 2)) begin
                mask_w[i*`SWPAC_LANE_W +: `SWPAC_LANE_W] = {`SWPAC_LANE_W{1'b1}};
            end
        end
        if (!wide) begin
            mask_w[`SWPAC_DATA_W-1:18] = '0;
        end
    end

    // ------------------------------------------------------------
    // address latches
    // ------------------------------------------------------------
    swpac_addr_t wa_q;
    swpac_addr_t ra_q;
    logic        rs_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= SWPAC_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // read address only on a selected positive phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ra_q <= '0;
            rs_q <= 1'b0;
        end else begin
            rs_q <= rd_go;
            if (rd_go) begin
                ra_q <= a_s & amask;
            end
        end
    end

    // write address only on the complementary phase of a started write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wa_q <= '0;
        end else if (beat_kb) begin
            wa_q <= a_s & amask;
        end
    end

    // ------------------------------------------------------------
    // beat buffer
    // ------------------------------------------------------------
    localparam int PDW = 1 + `SWPAC_DATA_W + `SWPAC_DATA_W;
    localparam int FW  = PDW + `SWPAC_ADDR_W;
    swpac_stream_if #(.WIDTH(FW)) fin ();
    swpac_stream_if #(.WIDTH(FW)) fout ();
    logic [PDW-1:0] pend_q;
    logic           pend_v_q;
    // first beat waits one step so the write address taken on the
    // complementary edge can travel with it through the fifo
    wire swpac_addr_t push_addr = beat_kb ? (a_s & amask) : wa_q;
    assign fin.valid  = pend_v_q;
    assign fin.data   = {pend_q, push_addr};
    assign fout.ready = wr_ready || !wr_valid;

    swpac_fifo #(.WIDTH(FW), .DEPTH(`SWPAC_FIFO_DEPTH)) u_fifo (
        .clk   (clk),
        .rst_n (rst_n),
        .in_s  (fin),
        .out_s (fout)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q   <= '0;
            pend_v_q <= 1'b0;
        end else begin
            pend_v_q <= take;
            pend_q   <= {beat_kb, d_s & mask_w, mask_w};
        end
    end

    // one cycle per beat lost to a full fifo
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stall <= 1'b0;
        end else begin
            stall <= pend_v_q && !fin.ready;
        end
    end

    // ------------------------------------------------------------
    // read outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_start <= 1'b0;
            rd_addr  <= '0;
        end else begin
            rd_start <= rs_q;
            rd_addr  <= ra_q;
        end
    end

    // ------------------------------------------------------------
    // write outputs
    // ------------------------------------------------------------
    // fifo word: beat index, data, bit mask, address
    wire              f_beat = fout.data[FW-1];
    wire swpac_data_t f_data = fout.data[FW-2 -: `SWPAC_DATA_W];
    wire swpac_data_t f_mask = fout.data[`SWPAC_ADDR_W +: `SWPAC_DATA_W];
    wire swpac_addr_t f_addr = fout.data[`SWPAC_ADDR_W-1:0];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_valid <= 1'b0;
            wr_beat  <= 1'b0;
        end else if (fout.ready) begin
            wr_valid <= fout.valid;
            wr_beat  <= f_beat;
        end
    end

    // beat held while the array is not ready
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_data    <= '0;
            wr_bitmask <= '0;
            wr_addr    <= '0;
        end else if (fout.ready) begin
            wr_data    <= f_data;
            wr_bitmask <= f_mask;
            wr_addr    <= f_addr;
        end
    end
endmodule : swpac_top
`default_nettype wire

// >>> testbench/swpac_asserts.sv
// port checker for swpac_top
// assumes binding to swpac_top, one clock
`timescale 1ns/10ps
`default_nettype none
module swpac_asserts
    import swpac_pkg::*;
(
    input wire logic        clk, rst_n, write_port_select_n, read_port_select_n,
    input wire logic        wide_cfg, wr_ready, wr_valid, wr_beat, rd_start,
    input wire swpac_addr_t wr_addr, rd_addr,
    input wire swpac_data_t wr_data, wr_bitmask
);
    // ----------------
    // idle counters
    // ----------------
    logic [4:0]  wi_q;
    logic [4:0]  ri_q;
    swpac_addr_t a0_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wi_q <= 5'h0;
            ri_q <= 5'h0;
            a0_q <= '0;
        end else begin
            wi_q <= (write_port_select_n && wr_ready) ? wi_q + {4'h0, ~&wi_q} : 5'h0;
            ri_q <= read_port_select_n ? ri_q + {4'h0, ~&ri_q} : 5'h0;
            if (wr_valid && wr_ready && !wr_beat)
                a0_q <= wr_addr;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    property p_masked; wr_valid |-> (wr_data & ~wr_bitmask) == '0; endproperty
    a_masked: assert property (p_masked) else $error("data outside lanes");
    property p_lanes; wr_valid |-> wr_bitmask == {{9{wr_bitmask[27]}},
        {9{wr_bitmask[18]}}, {9{wr_bitmask[9]}}, {9{wr_bitmask[0]}}}; endproperty
    a_lanes: assert property (p_lanes) else $error("lane not uniform");
    property p_narrow; wr_valid && !wide_cfg |-> wr_bitmask[35:18] == 18'h0; endproperty
    a_narrow: assert property (p_narrow) else $error("upper lanes in narrow");
    property p_stand; wr_valid && !wr_ready |=> wr_valid && $stable(wr_data)
        && $stable(wr_addr) && $stable(wr_bitmask) && $stable(wr_beat); endproperty
    a_stand: assert property (p_stand) else $error("beat changed");
    property p_pair; wr_valid && wr_beat |-> wr_addr == a0_q; endproperty
    a_pair: assert property (p_pair) else $error("beat address differs");
    property p_second; wr_valid && wr_ready && !wr_beat |-> ##[1:4] (wr_valid && wr_beat);
    endproperty
    a_second: assert property (p_second) else $error("second beat missing");
    property p_rdpulse; rd_start |=> !rd_start; endproperty
    a_rdpulse: assert property (p_rdpulse) else $error("read start too long");
    property p_nowr; wi_q >= 5'd28 |-> !wr_valid; endproperty
    a_nowr: assert property (p_nowr) else $error("beat while deselected");
    property p_rdkeep; ri_q >= 5'd4 |-> $stable(rd_addr); endproperty
    a_rdkeep: assert property (p_rdkeep) else $error("read address moved");
endmodule : swpac_asserts
bind swpac_top swpac_asserts i_swpac_asserts (.clk(clk), .rst_n(rst_n),
    .write_port_select_n(write_port_select_n), .read_port_select_n(read_port_select_n),
    .wide_cfg(wide_cfg), .wr_ready(wr_ready), .wr_valid(wr_valid), .wr_beat(wr_beat),
    .rd_start(rd_start), .wr_addr(wr_addr), .rd_addr(rd_addr), .wr_data(wr_data),
    .wr_bitmask(wr_bitmask));
`default_nettype wire

// >>> testbench/swpac_ctrl_model.sv
// memory controller model driving the pins
// assumes go inputs held for two clocks per burst
`timescale 1ns/10ps
`default_nettype none
module swpac_ctrl_model
    import swpac_pkg::*;
(
    input  wire logic         clk, rst_n, wr_go, rd_go,
    input  wire swpac_addr_t  w_addr, r_addr,
    input  wire swpac_data_t  d0, d1,
    input  wire swpac_lanes_t l0, l1,
    output logic              phase_k, wps_n, rps_n,
    output swpac_lanes_t      lanes_n,
    output swpac_addr_t       addr,
    output swpac_data_t       wdata
);
    // ----------------
    // pin sequencing
    // ----------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_k <= 1'b0;
            wps_n <= 1'b1;
            rps_n <= 1'b1;
            lanes_n <= '1;
            addr <= '0;
            wdata <= '0;
        end else if (!phase_k) begin
            phase_k <= 1'b1;
            wps_n <= ~wr_go;
            rps_n <= ~rd_go;
            addr <= rd_go ? r_addr : ~addr;
            wdata <= wr_go ? d0 : ~wdata;
            lanes_n <= wr_go ? l0 : ~lanes_n;
        end else begin
            phase_k <= 1'b0;
            wps_n <= 1'b1;
            rps_n <= 1'b1;
            addr <= !wps_n ? w_addr : ~addr;
            wdata <= !wps_n ? d1 : ~wdata;
            lanes_n <= !wps_n ? l1 : ~lanes_n;
        end
    end
endmodule : swpac_ctrl_model
`default_nettype wire

// >>> testbench/swpac_top_tb.sv
// self-checking bench for swpac_top
// assumes the controller model on the pin side
`timescale 1ns/10ps
`default_nettype none
module swpac_top_tb
    import swpac_pkg::*;
;
    logic         clk = 0, rst_n = 0, wr_go = 0, rd_go = 0, wide = 1, rdy = 1;
    logic         pk, wps_n, rps_n, wrv, wrb, rds, stall;
    swpac_addr_t  wa = '0, ra = '0, ad, wad, rad;
    swpac_data_t  d0 = '0, d1 = '0, wd, od, om;
    swpac_lanes_t l0 = '0, l1 = '0, ln;
    int           errors = 0, n_tests = 0;
    swpac_ctrl_model i_swpac_ctrl_model (.clk(clk), .rst_n(rst_n), .wr_go(wr_go),
        .rd_go(rd_go), .w_addr(wa), .r_addr(ra), .d0(d0), .d1(d1), .l0(l0), .l1(l1),
        .phase_k(pk), .wps_n(wps_n), .rps_n(rps_n), .lanes_n(ln), .addr(ad), .wdata(wd));
    swpac_top i_swpac_top (.clk(clk), .rst_n(rst_n), .phase_k(pk),
        .write_port_select_n(wps_n), .read_port_select_n(rps_n),
        .byte_lane_write_select_n(ln), .addr(ad), .wdata(wd), .wide_cfg(wide),
        .wr_ready(rdy), .wr_valid(wrv), .wr_addr(wad), .wr_beat(wrb), .wr_data(od),
        .wr_bitmask(om), .rd_start(rds), .rd_addr(rad), .stall(stall));
    // ----------------
    // helpers
    // ----------------
    initial forever #50 clk = ~clk;
    task give_verdict;
        $display("errors %0d tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    task chk(string nm, swpac_data_t e, swpac_data_t g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    function swpac_data_t mask(swpac_lanes_t l);
        for (int i = 0; i < 4; i++) mask[i*9+:9] = (!l[i] && (wide || i < 2)) ? 9'h1FF : 9'h0;
    endfunction : mask
    task take(logic b, swpac_data_t d, swpac_lanes_t l);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (!(wrv === 1'b1 && rdy) && k < 40);
        if (k >= 40) begin
            errors++;
            give_verdict();
        end
        chk("data", d & mask(l), od);
        chk("mask", mask(l), om);
        chk("addr", swpac_data_t'(wa), swpac_data_t'(wad));
        chk("beat", swpac_data_t'(b), swpac_data_t'(wrb));
    endtask : take
    task do_wr(swpac_lanes_t a, swpac_lanes_t b, swpac_data_t x, swpac_data_t y);
        @(posedge clk);
        l0 <= a;
        l1 <= b;
        d0 <= x;
        d1 <= y;
        wr_go <= 1'b1;
        repeat (2) @(posedge clk);
        wr_go <= 1'b0;
        take(1'b0, x, a);
        take(1'b1, y, b);
    endtask : do_wr
    // ----------------
    // scenarios
    // ----------------
    task sc_lanes;
        logic [3:0] t [4] = '{4'h0, 4'hA, 4'h5, 4'hE};
        for (int i = 0; i < 4; i++) begin
            wa <= 19'h7FFFF - 19'(i);
            ra <= 19'h00001 + 19'(i);
            do_wr(t[i], {t[i][0], t[i][3:1]}, 36'h123456789 + 36'(i), 36'hFEDCBA987);
        end
    endtask : sc_lanes
    task sc_narrow;
        wide <= 1'b0;
        wa <= 19'h2AAAA;
        do_wr(4'h0, 4'h4, 36'hFFFFFFFFF, 36'h0F0F0F0F0);
        wide <= 1'b1;
    endtask : sc_narrow
    task sc_read;
        int k;
        ra <= 19'h55555;
        @(posedge clk);
        rd_go <= 1'b1;
        repeat (2) @(posedge clk);
        rd_go <= 1'b0;
        for (k = 0; k < 20 && rds !== 1'b1; k++) @(posedge clk);
        if (rds !== 1'b1) begin
            errors++;
            give_verdict();
        end
        chk("rd_start", 36'h1, swpac_data_t'(rds));
        chk("rd_addr", swpac_data_t'(ra), swpac_data_t'(rad));
    endtask : sc_read
    task sc_idle;
        int n;
        n = 0;
        repeat (30) begin
            @(posedge clk);
            if (wrv === 1'b1) n++;
        end
        chk("idle beats", 36'h0, swpac_data_t'(n));
        chk("kept rd_addr", swpac_data_t'(ra), swpac_data_t'(rad));
    endtask : sc_idle
    task sc_stall;
        logic s;
        s = 1'b0;
        @(posedge clk);
        rdy <= 1'b0;
        wa <= 19'h0ABCD;
        wr_go <= 1'b1;
        for (int k = 0; k < 34; k++) begin
            @(posedge clk);
            if (k == 6) wa <= 19'h0DCBA;
            if (k == 24) wr_go <= 1'b0;
            if (stall === 1'b1) s = 1'b1;
        end
        chk("stall", 36'h1, swpac_data_t'(s));
        rdy <= 1'b1;
        wa <= 19'h0ABCD;
        take(1'b0, d0, l0);
        take(1'b1, d1, l1);
        repeat (40) @(posedge clk);
    endtask : sc_stall
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        sc_lanes();
        sc_narrow();
        sc_read();
        sc_idle();
        sc_stall();
        give_verdict();
    end
endmodule : swpac_top_tb
`default_nettype wire
